// ===== src/flash_cmd_pkg.sv
package flash_cmd_pkg;
   // Opcodes
   localparam logic [7:0] OP_SECURE_AREA_READ      = 8'h48;
   localparam logic [7:0] OP_DEEP_SLEEP_ENTRY      = 8'hb9;
   localparam logic [7:0] OP_DEEP_SLEEP_EXIT       = 8'hab;
   localparam logic [7:0] OP_LEGACY_SIGNATURE_READ = 8'hab;
   localparam logic [7:0] OP_MAKER_DEVICE_ID_READ  = 8'h90;
   localparam logic [7:0] OP_DUAL_MAKER_DEVICE_ID  = 8'h92;
   localparam logic [7:0] OP_QUAD_MAKER_DEVICE_ID  = 8'h94;
   // Identity codes (values arbitrary)
   localparam logic [7:0] MAKER_CODE               = 8'h5a;
   localparam logic [7:0] DEVICE_CODE              = 8'h3c;
   localparam logic [7:0] SIGNATURE_CODE           = 8'h3c;
   // Secure area address fields
   localparam int         AREA_SEL_LSB             = 12;
   localparam int         AREA_OFS_BITS            = 9;
   localparam int         AREA_WORDS               = 3 * 512;
   localparam logic [8:0] AREA_LAST_OFS            = 9'h1ff;
   // Phase lengths in bits (one link clock edge moves a lane step of bits)
   localparam logic [5:0] ADDR_DUMMY_BITS          = 6'h20;
   localparam logic [5:0] ID_HDR_BITS              = 6'h18;
   // Timing
   localparam int         CLK_MHZ                  = 50;
   localparam int         SLEEP_ENTRY_DELAY_NS     = 3000;
   localparam int         SLEEP_EXIT_DELAY_NS      = 8000;
   localparam int         SLEEP_ENTRY_CYC          = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int         SLEEP_EXIT_CYC           = (SLEEP_EXIT_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int         HOST_SCK_HALF            = 8;
   localparam logic [9:0] DELAY_RESET              = 10'h000;
   // Lane modes
   typedef enum logic [1:0] {LANE_X1 = 2'h0, LANE_X2 = 2'h1, LANE_X4 = 2'h2} lane_mode_t;
   // Power states
   typedef enum logic [1:0] {PWR_STANDBY = 2'h0, PWR_ENTERING = 2'h1, PWR_SLEEP = 2'h3,
                             PWR_WAKING = 2'h2} pwr_state_t;
endpackage

// ===== src/flash_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
   logic       cs_n;
   logic       sck;
   logic [3:0] host_io_o;
   logic [3:0] host_io_oe;
   logic [3:0] dev_io_o;
   logic [3:0] dev_io_oe;
   wire  [3:0] io;
   // Resolve each lane from the drivers; undriven reads high (pull-up)
   genvar g;
   for (g = 0; g < 4; g++) begin : g_lane
      assign io[g] = dev_io_oe[g] ? dev_io_o[g] : (host_io_oe[g] ? host_io_o[g] : 1'b1);
   end
   modport device (input cs_n, input sck, input io, output dev_io_o, output dev_io_oe);
   modport host (output cs_n, output sck, input io, output host_io_o, output host_io_oe);
endinterface
`default_nettype wire

// ===== src/flash_cmd_dev.sv
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_dev (
   // System
   input  wire logic        clk,
   input  wire logic        nrst,
   // Link
   flash_link_if.device     link,
   // Array side
   input  wire logic        write_busy,
   output logic             asleep,
   output logic             area_bad
);
   typedef enum logic [2:0] {
      ST_OPCODE = 3'h0, ST_HDR = 3'h1, ST_OUT = 3'h3, ST_IGNORE = 3'h2, ST_DONE = 3'h6
   } dev_state_t;
   typedef enum logic [1:0] {CMD_SEC = 2'h0, CMD_ID = 2'h1, CMD_SIG = 2'h2, CMD_NONE = 2'h3} cmd_t;

   logic [7:0]                  area_mem [flash_cmd_pkg::AREA_WORDS];
   logic [1:0]                  cs_s_r, sck_s_r;
   logic [3:0]                  io_s0_r, io_s1_r;
   logic                        sck_d_r, cs_d_r;
   logic                        rise, fall, cs_fall, cs_rise;
   dev_state_t                  st_r;
   cmd_t                        cmd_r;
   flash_cmd_pkg::lane_mode_t   mode_r;
   flash_cmd_pkg::pwr_state_t   pwr_r;
   logic [7:0]                  op_r;
   logic [3:0]                  opcnt_r;
   logic [5:0]                  hcnt_r;
   logic [23:0]                 addr_r;
   logic [7:0]                  shift_r;
   logic [3:0]                  ocnt_r;
   logic                        id_sel_r;
   logic [9:0]                  dly_r;
   logic                        op_exact_r;
   logic [3:0]                  lanes_en;

   // Lanes a mode drives
   function automatic logic [3:0] lane_mask(input flash_cmd_pkg::lane_mode_t m);
      unique case (m)
         flash_cmd_pkg::LANE_X1: lane_mask = 4'h2;
         flash_cmd_pkg::LANE_X2: lane_mask = 4'h3;
         default:                lane_mask = 4'hf;
      endcase
   endfunction

   // Bits moved per link edge
   function automatic logic [3:0] lane_step(input flash_cmd_pkg::lane_mode_t m);
      unique case (m)
         flash_cmd_pkg::LANE_X1: lane_step = 4'h1;
         flash_cmd_pkg::LANE_X2: lane_step = 4'h2;
         default:                lane_step = 4'h4;
      endcase
   endfunction

   // Byte index into the area memory from a full address
   function automatic int area_index(input logic [23:0] a);
      area_index = (int'(a[13:12]) - 1) * 512 + int'(a[8:0]);
   endfunction

   // Two-flop synchronisers for the link pins
   always_ff @(posedge clk) begin
      cs_s_r  <= {cs_s_r[0], link.cs_n};
      sck_s_r <= {sck_s_r[0], link.sck};
      io_s0_r <= link.io;
      io_s1_r <= io_s0_r;
   end

   // Edge detection on synchronised levels
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sck_d_r <= 1'b0;
         cs_d_r  <= 1'b1;
      end else begin
         sck_d_r <= sck_s_r[1];
         cs_d_r  <= cs_s_r[1];
      end
   end
   assign rise    = !cs_s_r[1] && sck_s_r[1] && !sck_d_r;
   assign fall    = !cs_s_r[1] && !sck_s_r[1] && sck_d_r;
   assign cs_fall = cs_d_r && !cs_s_r[1];
   assign cs_rise = !cs_d_r && cs_s_r[1];

   // Command sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r       <= ST_OPCODE;
         cmd_r      <= CMD_NONE;
         mode_r     <= flash_cmd_pkg::LANE_X1;
         op_r       <= 8'h00;
         opcnt_r    <= 4'h0;
         hcnt_r     <= 6'h00;
         addr_r     <= 24'h000000;
         op_exact_r <= 1'b0;
      end else if (cs_fall) begin
         st_r       <= ST_OPCODE;
         mode_r     <= flash_cmd_pkg::LANE_X1;
         opcnt_r    <= 4'h0;
         op_exact_r <= 1'b0;
      end else if (rise) begin
         unique case (st_r)
            ST_OPCODE: begin
               op_r    <= {op_r[6:0], io_s1_r[0]};
               opcnt_r <= opcnt_r + 4'h1;
               op_exact_r <= (opcnt_r == 4'h7);
               hcnt_r  <= 6'h00;
               if (opcnt_r == 4'h7) begin
                  if (pwr_r != flash_cmd_pkg::PWR_STANDBY &&
                      {op_r[6:0], io_s1_r[0]} != flash_cmd_pkg::OP_LEGACY_SIGNATURE_READ) begin
                     st_r <= ST_IGNORE;
                  end else begin
                     unique case ({op_r[6:0], io_s1_r[0]})
                        flash_cmd_pkg::OP_SECURE_AREA_READ: begin
                           cmd_r <= CMD_SEC;
                           st_r  <= ST_HDR;
                        end
                        flash_cmd_pkg::OP_MAKER_DEVICE_ID_READ: begin
                           cmd_r <= CMD_ID;
                           st_r  <= ST_HDR;
                        end
                        flash_cmd_pkg::OP_DUAL_MAKER_DEVICE_ID: begin
                           cmd_r  <= CMD_ID;
                           mode_r <= flash_cmd_pkg::LANE_X2;
                           st_r   <= ST_HDR;
                        end
                        flash_cmd_pkg::OP_QUAD_MAKER_DEVICE_ID: begin
                           cmd_r  <= CMD_ID;
                           mode_r <= flash_cmd_pkg::LANE_X4;
                           st_r   <= ST_HDR;
                        end
                        flash_cmd_pkg::OP_LEGACY_SIGNATURE_READ: begin
                           cmd_r <= write_busy ? CMD_NONE : CMD_SIG;
                           st_r  <= write_busy ? ST_IGNORE : ST_OUT;
                        end
                        default: begin
                           cmd_r <= CMD_NONE;
                           st_r  <= ST_DONE;
                        end
                     endcase
                  end
               end
            end
            ST_HDR: begin
               // Shift address and dummy bits, lane count wide
               unique case (mode_r)
                  flash_cmd_pkg::LANE_X1: addr_r <= {addr_r[22:0], io_s1_r[0]};
                  flash_cmd_pkg::LANE_X2: addr_r <= {addr_r[21:0], io_s1_r[1:0]};
                  default:                addr_r <= {addr_r[19:0], io_s1_r};
               endcase
               hcnt_r <= hcnt_r + 6'(lane_step(mode_r));
               if ((cmd_r == CMD_SEC && hcnt_r + 6'(lane_step(mode_r)) == flash_cmd_pkg::ADDR_DUMMY_BITS) ||
                   (cmd_r == CMD_ID && hcnt_r + 6'(lane_step(mode_r)) == flash_cmd_pkg::ID_HDR_BITS)) begin
                  st_r <= ST_OUT;
               end
               if (cmd_r == CMD_SEC && hcnt_r == 6'h17) begin
                  // Dummy byte follows; keep 24-bit address intact
                  st_r <= ST_HDR;
               end
            end
            default: begin
               op_exact_r <= 1'b0;
            end
         endcase
      end
   end

   // Secure address is captured once 24 bits are in; dummy bits go elsewhere; offset then steps per byte, wrapping after 1ff
   logic [23:0] sec_addr_r;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sec_addr_r <= 24'h000000;
      end else if (rise && st_r == ST_HDR && hcnt_r == 6'h17) begin
         sec_addr_r <= {addr_r[22:0], io_s1_r[0]};
      end else if (fall && st_r == ST_OUT && cmd_r == CMD_SEC && ocnt_r == 4'h0) begin
         if (sec_addr_r[8:0] == flash_cmd_pkg::AREA_LAST_OFS) begin
            sec_addr_r[8:0] <= 9'h000;
         end else begin
            sec_addr_r[8:0] <= sec_addr_r[8:0] + 9'h001;
         end
      end
   end

   // Bad area select flag: bits 23:16 or 11:9 nonzero or area not 1..3
   assign area_bad = (cmd_r == CMD_SEC) && (sec_addr_r[23:16] != 8'h00 || sec_addr_r[11:9] != 3'h0 ||
                     sec_addr_r[15:12] == 4'h0 || sec_addr_r[15:12] > 4'h3);

   // Output shifter on falling link edges
   always_ff @(posedge clk) begin
      if (!nrst) begin
         shift_r  <= 8'h00;
         ocnt_r   <= 4'h0;
         id_sel_r <= 1'b0;
      end else if (cs_fall) begin
         ocnt_r <= 4'h0;
      end else if (fall && st_r == ST_OUT) begin
         if (ocnt_r == 4'h0) begin
            unique case (cmd_r)
               CMD_SEC: shift_r <= area_bad ? 8'hff : area_mem[area_index(sec_addr_r)];
               CMD_SIG: shift_r <= flash_cmd_pkg::SIGNATURE_CODE;
               CMD_ID: begin
                  // Address byte picks the first code; then alternate
                  shift_r  <= (id_sel_r ^ addr_r[0]) ? flash_cmd_pkg::DEVICE_CODE
                                                      : flash_cmd_pkg::MAKER_CODE;
                  id_sel_r <= !id_sel_r;
               end
               default: shift_r <= 8'hff;
            endcase
            ocnt_r <= 4'(8 - int'(lane_step(mode_r)));
         end else begin
            shift_r <= shift_r << lane_step(mode_r);
            ocnt_r  <= ocnt_r - lane_step(mode_r);
         end
      end else if (st_r == ST_HDR) begin
         id_sel_r <= 1'b0;
      end
   end

   // Lane drive: only in data phase after the first falling edge
   logic out_live_r;
   always_ff @(posedge clk) begin
      if (!nrst || cs_s_r[1]) begin
         out_live_r <= 1'b0;
      end else if (fall && st_r == ST_OUT) begin
         out_live_r <= 1'b1;
      end
   end
   assign lanes_en       = out_live_r ? lane_mask(mode_r) : 4'h0;
   assign link.dev_io_oe = lanes_en;
   always_comb begin
      unique case (mode_r)
         flash_cmd_pkg::LANE_X1: link.dev_io_o = {2'b00, shift_r[7], 1'b0};
         flash_cmd_pkg::LANE_X2: link.dev_io_o = {2'b00, shift_r[7:6]};
         default:                link.dev_io_o = shift_r[7:4];
      endcase
   end

   // Power state machine, starts in standby at reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pwr_r <= flash_cmd_pkg::PWR_STANDBY;
         dly_r <= flash_cmd_pkg::DELAY_RESET;
      end else begin
         unique case (pwr_r)
            flash_cmd_pkg::PWR_STANDBY: begin
               if (cs_rise && op_exact_r && st_r == ST_DONE && op_r == flash_cmd_pkg::OP_DEEP_SLEEP_ENTRY) begin
                  pwr_r <= flash_cmd_pkg::PWR_ENTERING;
                  dly_r <= 10'(flash_cmd_pkg::SLEEP_ENTRY_CYC);
               end
            end
            flash_cmd_pkg::PWR_ENTERING: begin
               dly_r <= dly_r - 10'h001;
               if (dly_r == 10'h001) begin
                  pwr_r <= flash_cmd_pkg::PWR_SLEEP;
               end
            end
            flash_cmd_pkg::PWR_SLEEP: begin
               if (cs_rise && op_r == flash_cmd_pkg::OP_DEEP_SLEEP_EXIT && !write_busy &&
                   (op_exact_r || cmd_r == CMD_SIG)) begin
                  pwr_r <= flash_cmd_pkg::PWR_WAKING;
                  dly_r <= 10'(flash_cmd_pkg::SLEEP_EXIT_CYC);
               end
            end
            flash_cmd_pkg::PWR_WAKING: begin
               dly_r <= dly_r - 10'h001;
               if (dly_r == 10'h001) begin
                  pwr_r <= flash_cmd_pkg::PWR_STANDBY;
               end
            end
         endcase
      end
   end
   assign asleep = (pwr_r != flash_cmd_pkg::PWR_STANDBY);
endmodule
`default_nettype wire

// ===== src/flash_cmd_host.sv
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host (
   // System
   input  wire logic        clk,
   input  wire logic        nrst,
   // Link
   flash_link_if.host       link,
   // User request
   input  wire logic        req,
   input  wire logic [7:0]  req_op,
   input  wire logic [23:0] req_addr,
   input  wire logic [7:0]  req_rd_bytes,
   output logic             busy,
   output logic             rd_valid,
   output logic [7:0]       rd_data
);
   typedef enum logic [1:0] {H_IDLE = 2'h0, H_RUN = 2'h1, H_GAP = 2'h3} host_state_t;

   host_state_t               st_r;
   logic [2:0]                div_r;
   logic                      sck_r;
   logic [6:0]                bit_r;
   logic [6:0]                pos;
   logic [6:0]                tx_bits_r;
   logic [39:0]               tx_r;
   logic [7:0]                rx_r;
   logic [7:0]                left_r;
   logic [3:0]                rcnt_r;
   logic [9:0]                gap_r;
   flash_cmd_pkg::lane_mode_t mode_r;
   logic [3:0]                in_s0_r, in_s1_r;

   // Input lanes through two flops
   always_ff @(posedge clk) begin
      in_s0_r <= link.io;
      in_s1_r <= in_s0_r;
   end

   // Sequencer and clock divider
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r      <= H_IDLE;
         div_r     <= 3'h0;
         sck_r     <= 1'b0;
         bit_r     <= 7'h00;
         tx_bits_r <= 7'h00;
         tx_r      <= 40'h0;
         left_r    <= 8'h00;
         rcnt_r    <= 4'h0;
         rx_r      <= 8'h00;
         rd_valid  <= 1'b0;
         rd_data   <= 8'h00;
         gap_r     <= 10'h000;
         mode_r    <= flash_cmd_pkg::LANE_X1;
      end else begin
         rd_valid <= 1'b0;
         unique case (st_r)
            H_IDLE: if (req) begin
               st_r   <= H_RUN;
               div_r  <= 3'h0;
               bit_r  <= 7'h00;
               rcnt_r <= 4'h0;
               left_r <= req_rd_bytes;
               mode_r <= req_op == flash_cmd_pkg::OP_DUAL_MAKER_DEVICE_ID ? flash_cmd_pkg::LANE_X2 :
                         req_op == flash_cmd_pkg::OP_QUAD_MAKER_DEVICE_ID ? flash_cmd_pkg::LANE_X4 :
                         flash_cmd_pkg::LANE_X1;
               // Opcode, header, and bit count (header counted in lane steps)
               if (req_op == flash_cmd_pkg::OP_SECURE_AREA_READ) begin
                  tx_r      <= {req_op, req_addr, 8'h00};
                  tx_bits_r <= 7'd40;
               end else if (req_op == flash_cmd_pkg::OP_MAKER_DEVICE_ID_READ) begin
                  tx_r      <= {req_op, 16'h0000, req_addr[7:0], 8'h00};
                  tx_bits_r <= 7'd32;
               end else if (req_op == flash_cmd_pkg::OP_DUAL_MAKER_DEVICE_ID) begin
                  tx_r      <= {req_op, 16'h0000, req_addr[7:0], 8'h00};
                  tx_bits_r <= 7'd20;
               end else if (req_op == flash_cmd_pkg::OP_QUAD_MAKER_DEVICE_ID) begin
                  tx_r      <= {req_op, 16'h0000, req_addr[7:0], 8'h00};
                  tx_bits_r <= 7'd14;
               end else begin
                  tx_r      <= {req_op, 32'h0};
                  tx_bits_r <= 7'd8;
               end
            end
            H_RUN: begin
               div_r <= div_r + 3'h1;
               if (div_r == 3'(flash_cmd_pkg::HOST_SCK_HALF - 1)) begin
                  div_r <= 3'h0;
                  sck_r <= !sck_r;
                  if (sck_r) begin
                     // Falling edge: shift next header bits out
                     if (pos < 7'd8 || mode_r == flash_cmd_pkg::LANE_X1) begin
                        tx_r <= tx_r << 1;
                     end else if (mode_r == flash_cmd_pkg::LANE_X2) begin
                        tx_r <= tx_r << 2;
                     end else begin
                        tx_r <= tx_r << 4;
                     end
                     if (bit_r >= tx_bits_r && left_r == 8'h00) begin
                        st_r  <= H_GAP;
                        sck_r <= 1'b0;
                        gap_r <= 10'(flash_cmd_pkg::SLEEP_EXIT_CYC + 2);
                     end
                  end else begin
                     // Rising edge: sample input lanes in data phase
                     bit_r <= bit_r + 7'h01;
                     if (bit_r >= tx_bits_r && left_r != 8'h00) begin
                        unique case (mode_r)
                           flash_cmd_pkg::LANE_X1: rx_r <= {rx_r[6:0], in_s1_r[1]};
                           flash_cmd_pkg::LANE_X2: rx_r <= {rx_r[5:0], in_s1_r[1:0]};
                           default:                rx_r <= {rx_r[3:0], in_s1_r};
                        endcase
                        if (rcnt_r + 4'(mode_r == flash_cmd_pkg::LANE_X1 ? 1 :
                            mode_r == flash_cmd_pkg::LANE_X2 ? 2 : 4) == 4'h8) begin
                           rcnt_r   <= 4'h0;
                           left_r   <= left_r - 8'h01;
                           rd_valid <= 1'b1;
                           unique case (mode_r)
                              flash_cmd_pkg::LANE_X1: rd_data <= {rx_r[6:0], in_s1_r[1]};
                              flash_cmd_pkg::LANE_X2: rd_data <= {rx_r[5:0], in_s1_r[1:0]};
                              default:                rd_data <= {rx_r[3:0], in_s1_r};
                           endcase
                        end else begin
                           rcnt_r <= rcnt_r + 4'(mode_r == flash_cmd_pkg::LANE_X1 ? 1 :
                                     mode_r == flash_cmd_pkg::LANE_X2 ? 2 : 4);
                        end
                     end
                  end
               end
            end
            H_GAP: begin
               gap_r <= gap_r - 10'h001;
               if (gap_r == 10'h000) begin
                  st_r <= H_IDLE;
               end
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   // Pin drive; header lanes released once data phase begins
   assign link.cs_n = (st_r != H_RUN);
   assign link.sck  = sck_r;
   // Bit on the lanes; a rise counts it, but it must stand until the next fall
   assign pos       = sck_r ? bit_r - 7'h01 : bit_r;
   always_comb begin
      link.host_io_oe = 4'h0;
      link.host_io_o  = 4'h0;
      if (st_r == H_RUN && pos < tx_bits_r) begin
         if (pos < 7'd8 || mode_r == flash_cmd_pkg::LANE_X1) begin
            link.host_io_oe = 4'h1;
            link.host_io_o  = {3'h0, tx_r[39]};
         end else if (mode_r == flash_cmd_pkg::LANE_X2) begin
            link.host_io_oe = 4'h3;
            link.host_io_o  = {2'h0, tx_r[39:38]};
         end else begin
            link.host_io_oe = 4'hf;
            link.host_io_o  = tx_r[39:36];
         end
      end
   end
   assign busy = (st_r != H_IDLE);
endmodule
`default_nettype wire

// ===== tb/flash_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module flash_link_monitor (
   // System
   input wire logic       clk,
   input wire logic       nrst,
   // Link
   input wire logic       cs_n,
   input wire logic       sck,
   input wire logic [3:0] host_io_oe,
   input wire logic [3:0] dev_io_oe
);
   logic       sck_q;
   logic       sel_r;
   logic [7:0] rise_r;
   logic [9:0] gap_r;
   // Count link clock rises within a frame
   always_ff @(posedge clk) begin
      sck_q <= sck;
      if (!nrst || cs_n) rise_r <= 8'h00;
      else if (sck && !sck_q && rise_r != 8'hff) rise_r <= rise_r + 8'h01;
   end
   // Count deselected cycles between frames
   always_ff @(posedge clk) begin
      if (!nrst) sel_r <= 1'b0;
      else if (!cs_n) sel_r <= 1'b1;
      if (!nrst || !cs_n) gap_r <= 10'h000;
      else if (gap_r != 10'h3ff) gap_r <= gap_r + 10'h001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_IDLE_NO_DRIVE: assert property (cs_n [*4] |-> dev_io_oe == 4'h0)
      else $error("device drives while deselected");
   AST_SELECT_NO_DRIVE: assert property ($fell(cs_n) |-> (dev_io_oe == 4'h0) [*8])
      else $error("device drives during opcode");
   AST_OE_AFTER_OPCODE: assert property (!cs_n && dev_io_oe != 4'h0 |-> rise_r >= 8'h08)
      else $error("device drives before opcode complete");
   AST_NO_CONTENTION: assert property ((dev_io_oe & host_io_oe) == 4'h0)
      else $error("both ends drive one lane");
   AST_OE_LANE_SET: assert property (dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("device lane set illegal");
   AST_SCK_SELECTED: assert property ($rose(sck) |-> !cs_n)
      else $error("link clock rises while deselected");
   AST_SCK_IDLE_LOW: assert property (cs_n [*8] |-> !sck)
      else $error("link clock not idle low");
   AST_RESELECT_GAP: assert property ($fell(cs_n) && sel_r |-> gap_r >= flash_cmd_pkg::SLEEP_EXIT_CYC)
      else $error("reselect before exit delay");
   // Main scenarios
   cover property (dev_io_oe == 4'h2);
   cover property (dev_io_oe == 4'h3);
   cover property (dev_io_oe == 4'hf);
endmodule
`default_nettype wire

// ===== tb/flash_secreg_sleep_id_cmds_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_secreg_sleep_id_cmds_tb;
   localparam logic [7:0] M = flash_cmd_pkg::MAKER_CODE;
   localparam logic [7:0] D = flash_cmd_pkg::DEVICE_CODE;
   typedef struct {logic [7:0] op; logic [23:0] addr; logic [31:0] exp;} row_t;
   logic        clk, nrst, req, busy, rd_valid, write_busy, asleep, area_bad;
   logic [7:0]  req_op, req_rd_bytes, rd_data;
   logic [23:0] req_addr;
   logic [7:0]  got [4];
   int          nrx, fails, tests_run, cyc;
   row_t rows [8] = '{'{8'h90, 24'h0, {M, D, M, D}}, '{8'h90, 24'h1, {D, M, D, M}},
      '{8'h92, 24'h0, {M, D, M, D}}, '{8'h92, 24'h1, {D, M, D, M}}, '{8'h94, 24'h0, {M, D, M, D}},
      '{8'h94, 24'h1, {D, M, D, M}}, '{8'hab, 24'h0, {4{flash_cmd_pkg::SIGNATURE_CODE}}},
      '{8'h48, 24'h004000, 32'hffffffff}};
   flash_link_if link_if ();
   flash_cmd_dev i_flash_cmd_dev (.clk(clk), .nrst(nrst), .link(link_if), .write_busy(write_busy),
      .asleep(asleep), .area_bad(area_bad));
   flash_cmd_host i_flash_cmd_host (.clk(clk), .nrst(nrst), .link(link_if), .req(req), .req_op(req_op),
      .req_addr(req_addr), .req_rd_bytes(req_rd_bytes), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data));
   flash_link_monitor i_flash_link_monitor (.clk(clk), .nrst(nrst), .cs_n(link_if.cs_n), .sck(link_if.sck),
      .host_io_oe(link_if.host_io_oe), .dev_io_oe(link_if.dev_io_oe));
   always #10 clk = ~clk;
   // Collect read bytes and cut a hang short
   always @(negedge clk) begin
      if (rd_valid === 1'b1 && nrx < 4) got[nrx] = rd_data;
      if (rd_valid === 1'b1) nrx++;
      cyc++;
      if (cyc == 60000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic xfer(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] n);
      int k;
      nrx = 0;
      foreach (got[i]) got[i] = 8'hxx;
      req_op = op;
      req_addr = addr;
      req_rd_bytes = n;
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      for (k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge clk);
      chk("busy", busy, 0);
      repeat (flash_cmd_pkg::SLEEP_EXIT_CYC + 4) @(negedge clk);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {clk, nrst, req, req_op, req_addr, req_rd_bytes, write_busy, nrx, fails, tests_run, cyc} = '0;
      // Known bytes at both ends of area 3 for the wrap check
      i_flash_cmd_dev.area_mem[1534] = 8'h11;
      i_flash_cmd_dev.area_mem[1535] = 8'h22;
      i_flash_cmd_dev.area_mem[1024] = 8'h33;
      i_flash_cmd_dev.area_mem[1025] = 8'h44;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      chk("asleep", asleep, 0);
      foreach (rows[i]) begin
         xfer(rows[i].op, rows[i].addr, 8'h04);
         chk("bytes", {got[0], got[1], got[2], got[3]}, rows[i].exp);
      end
      chk("area_bad", area_bad, 1);
      xfer(8'h48, 24'h0031fe, 8'h04);
      chk("area_bad", area_bad, 0);
      chk("wrap", {got[0], got[1], got[2], got[3]}, 32'h11223344);
      xfer(8'hb9, 24'h0, 8'h00);
      chk("asleep", asleep, 1);
      xfer(8'h90, 24'h0, 8'h02);
      chk("ignored", {got[0], got[1]}, 16'hffff);
      write_busy = 1'b1;
      xfer(8'hab, 24'h0, 8'h00);
      chk("asleep", asleep, 1);
      write_busy = 1'b0;
      xfer(8'hab, 24'h0, 8'h00);
      chk("asleep", asleep, 0);
      xfer(8'h90, 24'h0, 8'h02);
      chk("woken", {got[0], got[1]}, {M, D});
      stop_test();
   end
endmodule
`default_nettype wire
